// *** pcmc_pkg.sv ***
// Constants for the host-side write/erase sequencer of a parallel phase-change memory.
// Assumes a 250 MHz system clock and a 16-bit asynchronous memory bus.
package pcmc_pkg;
   // ==========================================================
   // Widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 23;
   localparam int BLK_SHIFT = 16;
   localparam int BUF_DEPTH = 32;
   localparam int CNT_W = 5;
   localparam int APB_AW = 8;

   // ==========================================================
   // Memory command codes
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
   localparam logic [7:0] CMD_BUF_ALTER = 8'hEA;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

   // ==========================================================
   // Status word bit positions
   localparam int ENGINE_READY_BIT = 7;
   localparam int ERASE_FAIL_BIT = 5;
   localparam int PROGRAM_FAIL_BIT = 4;
   localparam int SUPPLY_FAULT_BIT = 3;
   localparam int PROGRAM_SUSPENDED_BIT = 2;
   localparam int LOCKED_BLOCK_ABORT_BIT = 1;

   // ==========================================================
   // Register map
   localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] REG_ADDR = 8'h04;
   localparam logic [APB_AW-1:0] REG_COUNT = 8'h08;
   localparam logic [APB_AW-1:0] REG_WDATA = 8'h0C;
   localparam logic [APB_AW-1:0] REG_STAT = 8'h10;
   localparam logic [APB_AW-1:0] REG_RDATA = 8'h14;
   localparam int CTRL_BITALT_POS = 4;
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_REFUSED_POS = 1;
   localparam int STAT_ERR_POS = 2;
   localparam int STAT_SUSP_POS = 3;
   localparam int STAT_UNALIGN_POS = 4;
   localparam int STAT_SR_LSB = 8;

   // ==========================================================
   // Operation codes written to CTRL[3:0]
   typedef enum logic [3:0] {
      OP_SUSPEND = 4'h1,
      OP_RESUME = 4'h2,
      OP_BUF_PROG = 4'h3,
      OP_ERASE = 4'h4,
      OP_READ_ARRAY = 4'h5,
      OP_CLEAR = 4'h6,
      OP_STATUS = 4'h7
   } pcmc_op_t;

   // ==========================================================
   // Sequencer states, Gray along the buffered-program path
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_CMD1 = 4'b0001,
      ST_POLL = 4'b0011,
      ST_COUNT = 4'b0010,
      ST_DATA = 4'b0110,
      ST_CONF = 4'b0111,
      ST_DONE_POLL = 4'b0101,
      ST_FINAL = 4'b0100,
      ST_CMD2 = 4'b1100,
      ST_ARRAY = 4'b1101
   } pcmc_state_t;

   typedef enum logic [1:0] {
      CY_IDLE = 2'b00,
      CY_SETUP = 2'b01,
      CY_STROBE = 2'b11,
      CY_HOLD = 2'b10
   } pcmc_cyc_t;

   // ==========================================================
   // Bus cycle timing
   localparam int CLK_MHZ = 250;
   localparam int T_SETUP_NS = 10;
   localparam int T_STROBE_NS = 140;
   localparam int T_HOLD_NS = 20;
   localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int TCNT_W = 8;
endpackage

// *** pcmc_bus_cycle.sv ***
// One asynchronous write or read cycle on the memory pins.
// Assumes the memory is the only load; DQ is sampled through two flip-flops.
`timescale 1ns/100ps
module pcmc_bus_cycle (
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic go_i,
   input wire logic wr_i,
   input wire logic [pcmc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [pcmc_pkg::DATA_W-1:0] wdata_i,
   output logic done_o,
   output logic [pcmc_pkg::DATA_W-1:0] rdata_o,
   output logic idle_o,
   input wire logic [pcmc_pkg::DATA_W-1:0] mem_dq_i,
   output logic [pcmc_pkg::ADDR_W-1:0] mem_addr_o,
   output logic [pcmc_pkg::DATA_W-1:0] mem_dq_o,
   output logic mem_dq_oe_n_o,
   output logic mem_ce_n_o,
   output logic mem_oe_n_o,
   output logic mem_we_n_o
);
   import pcmc_pkg::*;

   pcmc_cyc_t ph_q, ph_d;
   logic [TCNT_W-1:0] cnt_q, cnt_d;
   logic wr_q, wr_d, done_q, done_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d, sync1_q, sync2_q;
   logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dqoe_n_q, dqoe_n_d;

   // ==========================================================
   // Cycle sequencing
   // Strobe is long enough to cover the two-flop lag on DQ
   always_comb begin
      ph_d = ph_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      done_d = 1'b0;
      ce_n_d = ce_n_q;
      oe_n_d = oe_n_q;
      we_n_d = we_n_q;
      dqoe_n_d = dqoe_n_q;
      case (ph_q)
         CY_IDLE: begin
            if (go_i) begin
               ph_d = CY_SETUP;
               cnt_d = TCNT_W'(SETUP_CYC - 1);
               wr_d = wr_i;
               addr_d = addr_i;
               wdat_d = wdata_i;
               ce_n_d = 1'b0;
               dqoe_n_d = ~wr_i;
            end
         end
         CY_SETUP: begin
            if (cnt_q == '0) begin
               ph_d = CY_STROBE;
               cnt_d = TCNT_W'(STROBE_CYC - 1);
               we_n_d = ~wr_q;
               oe_n_d = wr_q;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         CY_STROBE: begin
            if (cnt_q == '0) begin
               ph_d = CY_HOLD;
               cnt_d = TCNT_W'(HOLD_CYC - 1);
               we_n_d = 1'b1;
               oe_n_d = 1'b1;
               if (!wr_q) begin
                  rdat_d = sync2_q;
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         CY_HOLD: begin
            if (cnt_q == '0) begin
               // Chip select rises so every read is a fresh strobe
               ph_d = CY_IDLE;
               ce_n_d = 1'b1;
               dqoe_n_d = 1'b1;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            ph_d = CY_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ph_q <= CY_IDLE;
         cnt_q <= '0;
         wr_q <= 1'b0;
         addr_q <= '0;
         wdat_q <= '0;
         rdat_q <= '0;
         done_q <= 1'b0;
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         dqoe_n_q <= 1'b1;
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         done_q <= done_d;
         ce_n_q <= ce_n_d;
         oe_n_q <= oe_n_d;
         we_n_q <= we_n_d;
         dqoe_n_q <= dqoe_n_d;
         sync1_q <= mem_dq_i;
         sync2_q <= sync1_q;
      end
   end

   assign done_o = done_q;
   assign rdata_o = rdat_q;
   assign idle_o = (ph_q == CY_IDLE) && !done_q;
   assign mem_addr_o = addr_q;
   assign mem_dq_o = wdat_q;
   assign mem_dq_oe_n_o = dqoe_n_q;
   assign mem_ce_n_o = ce_n_q;
   assign mem_oe_n_o = oe_n_q;
   assign mem_we_n_o = we_n_q;
endmodule

// *** pcmc_host.sv ***
// Host controller that drives suspend, resume, buffered program, erase,
// status and array reads on a parallel phase-change memory.
// Assumes software on APB; the memory answers on its own async pins.
`timescale 1ns/100ps
module pcmc_host (
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [pcmc_pkg::APB_AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic [pcmc_pkg::ADDR_W-1:0] MEM_ADDR_O,
   input wire logic [pcmc_pkg::DATA_W-1:0] MEM_DQ_I,
   output logic [pcmc_pkg::DATA_W-1:0] MEM_DQ_O,
   output logic MEM_DQ_OE_N_O,
   output logic MEM_CE_N_O,
   output logic MEM_OE_N_O,
   output logic MEM_WE_N_O
);
   import pcmc_pkg::*;

   // ==========================================================
   // Software registers
   logic apb_wr, apb_setup, mapped;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [CNT_W-1:0] count_q, count_d, wptr_q, wptr_d;
   logic [DATA_W-1:0] buf_q [BUF_DEPTH];
   logic [31:0] prdata_q, prdata_d;
   logic slverr_q, slverr_d;
   logic start_req;

   assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
   assign apb_setup = PSEL_I && !PENABLE_I;
   assign start_req = apb_wr && (PADDR_I == REG_CTRL);
   assign mapped = (PADDR_I == REG_CTRL) || (PADDR_I == REG_ADDR) || (PADDR_I == REG_COUNT)
      || (PADDR_I == REG_WDATA) || (PADDR_I == REG_STAT) || (PADDR_I == REG_RDATA);

   // ==========================================================
   // Sequencer state
   pcmc_state_t st_q, st_d;
   pcmc_op_t op_q, op_d;
   logic bitalt_q, bitalt_d, issued_q, issued_d;
   logic [CNT_W-1:0] idx_q, idx_d;
   logic [7:0] sr_q, sr_d;
   logic err_q, err_d, susp_q, susp_d, refused_q, refused_d, unalign_q, unalign_d;
   logic [ADDR_W-1:BLK_SHIFT] susp_blk_q, susp_blk_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [ADDR_W:0] last_addr;
   logic crosses, refuse, sr_ready, sr_error;

   // Bus cycle hand-off
   logic cyc_go, cyc_wr, cyc_done, cyc_idle;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_wdata, cyc_rdata;

   assign last_addr = {1'b0, addr_q} + {{(ADDR_W + 1 - CNT_W){1'b0}}, count_q};
   // Keep every data word inside the setup block
   assign crosses = last_addr[ADDR_W:BLK_SHIFT] != {1'b0, addr_q[ADDR_W-1:BLK_SHIFT]};
   assign sr_ready = cyc_rdata[ENGINE_READY_BIT];
   // Any error bit, including sequence error as bits 4 and 5 together
   assign sr_error = cyc_rdata[SUPPLY_FAULT_BIT] || cyc_rdata[PROGRAM_FAIL_BIT]
      || cyc_rdata[ERASE_FAIL_BIT] || cyc_rdata[LOCKED_BLOCK_ABORT_BIT];

   // ==========================================================
   // Acceptance of a new operation
   always_comb begin
      refuse = (st_q != ST_IDLE);
      case (PWDATA_I[3:0])
         OP_SUSPEND, OP_ERASE: begin
            // No retry while error bits stand uncleared
            refuse = refuse || err_q;
         end
         OP_BUF_PROG: begin
            refuse = refuse || err_q || crosses;
         end
         OP_READ_ARRAY: begin
            // Suspended block holds partial data
            refuse = refuse || (susp_q && (addr_q[ADDR_W-1:BLK_SHIFT] == susp_blk_q));
         end
         OP_RESUME: begin
            refuse = refuse || !susp_q;
         end
         OP_CLEAR, OP_STATUS: begin
            refuse = refuse;
         end
         default: begin
            refuse = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // Command sequencing
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      bitalt_d = bitalt_q;
      issued_d = issued_q;
      idx_d = idx_q;
      sr_d = sr_q;
      err_d = err_q;
      susp_d = susp_q;
      susp_blk_d = susp_blk_q;
      refused_d = refused_q;
      unalign_d = unalign_q;
      rdata_d = rdata_q;
      cyc_go = 1'b0;
      cyc_wr = 1'b1;
      cyc_addr = addr_q;
      cyc_wdata = '0;
      if (start_req) begin
         refused_d = refuse;
         if (!refuse) begin
            op_d = pcmc_op_t'(PWDATA_I[3:0]);
            bitalt_d = PWDATA_I[CTRL_BITALT_POS];
            st_d = ST_CMD1;
            issued_d = 1'b0;
            // Misaligned start only costs speed, so it is reported, not refused
            unalign_d = (PWDATA_I[3:0] == OP_BUF_PROG) && (addr_q[4:0] != 5'h0_0);
         end
      end
      if (st_q != ST_IDLE) begin
         cyc_go = !issued_q && cyc_idle;
         if (cyc_go) begin
            issued_d = 1'b1;
         end
         if (cyc_done) begin
            issued_d = 1'b0;
         end
      end
      case (st_q)
         ST_IDLE: begin
            cyc_go = 1'b0;
         end
         ST_CMD1: begin
            case (op_q)
               OP_SUSPEND, OP_STATUS: cyc_wdata = DATA_W'(CMD_READ_STATUS);
               OP_RESUME: cyc_wdata = DATA_W'(CMD_CONFIRM);
               OP_BUF_PROG: cyc_wdata = DATA_W'(bitalt_q ? CMD_BUF_ALTER : CMD_BUF_PROG);
               OP_ERASE: cyc_wdata = DATA_W'(CMD_ERASE_SETUP);
               OP_READ_ARRAY: cyc_wdata = DATA_W'(CMD_READ_ARRAY);
               default: cyc_wdata = DATA_W'(CMD_CLEAR_STATUS);
            endcase
            if (cyc_done) begin
               case (op_q)
                  OP_SUSPEND, OP_ERASE: st_d = ST_CMD2;
                  OP_BUF_PROG: st_d = ST_POLL;
                  OP_READ_ARRAY: st_d = ST_ARRAY;
                  OP_STATUS: st_d = ST_DONE_POLL;
                  OP_RESUME: begin
                     st_d = ST_IDLE;
                     susp_d = 1'b0;
                  end
                  default: begin
                     // Only the clear command drops the error view
                     st_d = ST_IDLE;
                     err_d = 1'b0;
                     sr_d = '0;
                  end
               endcase
            end
         end
         ST_CMD2: begin
            // Suspend address is ignored; erase confirm goes to the block
            cyc_wdata = DATA_W'((op_q == OP_SUSPEND) ? CMD_SUSPEND : CMD_CONFIRM);
            if (cyc_done) begin
               st_d = (op_q == OP_SUSPEND) ? ST_POLL : ST_DONE_POLL;
            end
         end
         ST_POLL: begin
            // Fresh read each pass until the engine is ready
            cyc_wr = 1'b0;
            if (cyc_done) begin
               sr_d = cyc_rdata[7:0];
               if (sr_ready) begin
                  if (op_q == OP_SUSPEND) begin
                     st_d = ST_IDLE;
                     susp_d = cyc_rdata[PROGRAM_SUSPENDED_BIT];
                     susp_blk_d = addr_q[ADDR_W-1:BLK_SHIFT];
                  end else begin
                     st_d = ST_COUNT;
                  end
               end
            end
         end
         ST_COUNT: begin
            cyc_wdata = DATA_W'(count_q);
            if (cyc_done) begin
               st_d = ST_DATA;
               idx_d = '0;
            end
         end
         ST_DATA: begin
            cyc_addr = addr_q + ADDR_W'(idx_q);
            cyc_wdata = buf_q[idx_q];
            if (cyc_done) begin
               if (idx_q == count_q) begin
                  st_d = ST_CONF;
               end else begin
                  idx_d = idx_q + 1'b1;
               end
            end
         end
         ST_CONF: begin
            cyc_wdata = DATA_W'(CMD_CONFIRM);
            if (cyc_done) begin
               st_d = ST_DONE_POLL;
            end
         end
         ST_DONE_POLL: begin
            // Completion poll; errors latch until cleared
            cyc_wr = 1'b0;
            if (cyc_done) begin
               sr_d = cyc_rdata[7:0];
               if (sr_ready) begin
                  err_d = err_q || sr_error;
                  st_d = (op_q == OP_STATUS) ? ST_IDLE : ST_FINAL;
               end
            end
         end
         ST_FINAL: begin
            cyc_wdata = DATA_W'(CMD_READ_ARRAY);
            if (cyc_done) begin
               st_d = ST_IDLE;
            end
         end
         ST_ARRAY: begin
            cyc_wr = 1'b0;
            if (cyc_done) begin
               rdata_d = cyc_rdata;
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // APB register next values
   always_comb begin
      addr_d = addr_q;
      count_d = count_q;
      wptr_d = wptr_q;
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (apb_wr && (PADDR_I == REG_ADDR)) begin
         addr_d = PWDATA_I[ADDR_W-1:0];
      end
      if (apb_wr && (PADDR_I == REG_COUNT)) begin
         count_d = PWDATA_I[CNT_W-1:0];
         wptr_d = '0;
      end
      if (apb_wr && (PADDR_I == REG_WDATA)) begin
         wptr_d = wptr_q + 1'b1;
      end
      // Read data and error are prepared in the setup cycle so they come from flops
      if (apb_setup) begin
         slverr_d = !mapped;
         prdata_d = '0;
         case (PADDR_I)
            REG_ADDR: prdata_d = 32'(addr_q);
            REG_COUNT: prdata_d = 32'(count_q);
            REG_RDATA: prdata_d = 32'(rdata_q);
            REG_STAT: begin
               prdata_d[STAT_BUSY_POS] = (st_q != ST_IDLE);
               prdata_d[STAT_REFUSED_POS] = refused_q;
               prdata_d[STAT_ERR_POS] = err_q;
               prdata_d[STAT_SUSP_POS] = susp_q;
               prdata_d[STAT_UNALIGN_POS] = unalign_q;
               prdata_d[STAT_SR_LSB +: 8] = sr_q;
            end
            default: prdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (apb_wr && (PADDR_I == REG_WDATA)) begin
         buf_q[wptr_q] <= PWDATA_I[DATA_W-1:0];
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         addr_q <= '0;
         count_q <= '0;
         wptr_q <= '0;
         prdata_q <= '0;
         slverr_q <= 1'b0;
         st_q <= ST_IDLE;
         op_q <= OP_STATUS;
         bitalt_q <= 1'b0;
         issued_q <= 1'b0;
         idx_q <= '0;
         sr_q <= '0;
         err_q <= 1'b0;
         susp_q <= 1'b0;
         susp_blk_q <= '0;
         refused_q <= 1'b0;
         unalign_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         addr_q <= addr_d;
         count_q <= count_d;
         wptr_q <= wptr_d;
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
         st_q <= st_d;
         op_q <= op_d;
         bitalt_q <= bitalt_d;
         issued_q <= issued_d;
         idx_q <= idx_d;
         sr_q <= sr_d;
         err_q <= err_d;
         susp_q <= susp_d;
         susp_blk_q <= susp_blk_d;
         refused_q <= refused_d;
         unalign_q <= unalign_d;
         rdata_q <= rdata_d;
      end
   end

   assign PRDATA_O = prdata_q;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_q;

   // ==========================================================
   // Memory pin cycles
   pcmc_bus_cycle u_cyc (
      .CLK_SYS_I(CLK_SYS_I),
      .NRST_I(NRST_I),
      .go_i(cyc_go),
      .wr_i(cyc_wr),
      .addr_i(cyc_addr),
      .wdata_i(cyc_wdata),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .idle_o(cyc_idle),
      .mem_dq_i(MEM_DQ_I),
      .mem_addr_o(MEM_ADDR_O),
      .mem_dq_o(MEM_DQ_O),
      .mem_dq_oe_n_o(MEM_DQ_OE_N_O),
      .mem_ce_n_o(MEM_CE_N_O),
      .mem_oe_n_o(MEM_OE_N_O),
      .mem_we_n_o(MEM_WE_N_O)
   );
endmodule

// *** pcmc_host_chk.sv ***
// Memory-bus and APB checker for the host sequencer.
// Bound to pcmc_host; sees its ports only.
`timescale 1ns/100ps
module pcmc_host_chk (
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [pcmc_pkg::APB_AW-1:0] PADDR_I,
   input wire logic PSLVERR_O,
   input wire logic [pcmc_pkg::ADDR_W-1:0] MEM_ADDR_O,
   input wire logic [pcmc_pkg::DATA_W-1:0] MEM_DQ_O,
   input wire logic MEM_DQ_OE_N_O,
   input wire logic MEM_CE_N_O,
   input wire logic MEM_OE_N_O,
   input wire logic MEM_WE_N_O
);
   import pcmc_pkg::*;
   logic we_q;
   logic [7:0] cmd_q;
   logic [6:0] blk_q;
   wire wfall = we_q & ~MEM_WE_N_O;
   // ==========================================
   // Previous command word, caught at its strobe
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         we_q <= 1'b1;
         cmd_q <= 8'h00;
         blk_q <= 7'h00;
      end else begin
         we_q <= MEM_WE_N_O;
         cmd_q <= wfall ? MEM_DQ_O[7:0] : cmd_q;
         blk_q <= wfall ? MEM_ADDR_O[22:16] : blk_q;
      end
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   sequence s_low; !MEM_WE_N_O [*8]; endsequence
   property p_width; $fell(MEM_WE_N_O) |-> s_low ##28 $rose(MEM_WE_N_O); endproperty
   a_width: assert property (p_width) else $error("write strobe width wrong");
   property p_setup; $fell(MEM_WE_N_O) |-> !$past(MEM_CE_N_O, 3) && $past(MEM_CE_N_O, 4); endproperty
   a_setup: assert property (p_setup) else $error("chip select setup wrong");
   property p_drive; !MEM_WE_N_O |-> !MEM_CE_N_O && !MEM_DQ_OE_N_O; endproperty
   a_drive: assert property (p_drive) else $error("write without data drive");
   property p_rdfloat; !MEM_OE_N_O |-> !MEM_CE_N_O && MEM_DQ_OE_N_O && MEM_WE_N_O; endproperty
   a_rdfloat: assert property (p_rdfloat) else $error("read while driving");
   property p_gap; $rose(MEM_CE_N_O) |=> MEM_CE_N_O; endproperty
   a_gap: assert property (p_gap) else $error("cycles too close");
   property p_slverr; PSEL_I && PENABLE_I && PADDR_I == 8'h18 |-> PSLVERR_O; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
   property p_susp; wfall && MEM_DQ_O == 16'h00B0 |-> cmd_q == CMD_READ_STATUS; endproperty
   a_susp: assert property (p_susp) else $error("suspend not after status command");
   property p_erblk; wfall && MEM_DQ_O == 16'h00D0 && cmd_q == 8'h20 |-> MEM_ADDR_O[22:16] == blk_q; endproperty
   a_erblk: assert property (p_erblk) else $error("erase confirm to other block");
endmodule

// *** pcmc_mem_model.sv ***
// Behavioural phase-change memory: command decoder, status word, small array.
// Assumes CE stays low around every WE or OE strobe.
`timescale 1ns/100ps
module pcmc_mem_model (
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [22:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic fault_i,
   output logic [15:0] dq_o
);
   logic [15:0] mem [logic [22:0]];
   logic [7:0] sr = 8'h80;
   logic [15:0] last = 16'h0000;
   logic [6:0] blk = 7'h00;
   logic stat = 1'b0;
   int phase = 0;
   int left = 0;
   int busy = 0;
   // ==========================================
   // Released bus shows the inverse, never a stale word
   assign dq_o = (!ce_n_i && !oe_n_i) ? last : ~last;
   always @(posedge we_n_i) if (!ce_n_i) begin
      stat = 1'b1;
      case (phase)
         1: begin
            left = dq_i[4:0] + 1;
            phase = 2;
         end
         2: begin
            if (addr_i[22:16] != blk) sr[5:4] = 2'b11;
            mem[addr_i] = dq_i;
            left--;
            if (left == 0) phase = 3;
         end
         3, 4: begin
            if (phase == 4 && fault_i) sr[5] = 1'b1;
            else if (phase == 4) foreach (mem[a]) if (a[22:16] == blk) mem[a] = 16'hFFFF;
            phase = 0;
            busy = 3;
         end
         default: case (dq_i[7:0])
            8'hE8, 8'hEA, 8'h20: begin
               blk = addr_i[22:16];
               phase = (dq_i[7:0] == 8'h20) ? 4 : 1;
            end
            8'hB0: begin
               sr[2] = (busy > 0) || fault_i;
               busy = 0;
            end
            8'hD0: sr[2] = 1'b0;
            8'h50: sr = sr & 8'hC4;
            8'hFF: stat = 1'b0;
            default: ;
         endcase
      endcase
   end
   always @(negedge oe_n_i) if (!ce_n_i) begin
      if (!stat) last = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF;
      else begin
         if (busy > 0) busy--;
         sr[7] = (busy == 0);
         last = {8'h00, sr};
      end
   end
endmodule

// *** pcmc_host_test.sv ***
// Self-checking bench for pcmc_host with a behavioural memory.
// Assumes the APB slave answers with zero wait states.
`timescale 1ns/100ps
module pcmc_host_test;
   import pcmc_pkg::*;
   logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, fault = 0, slv, rdy, serr;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0000_0000, prd, r;
   logic [22:0] ma;
   logic [15:0] dqo, dqi;
   logic oen, ce, oe, we;
   int fail_count = 0, samples_checked = 0;
   always #2 clk = ~clk;
   pcmc_host u_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr), .MEM_ADDR_O(ma),
      .MEM_DQ_I(dqi), .MEM_DQ_O(dqo), .MEM_DQ_OE_N_O(oen), .MEM_CE_N_O(ce), .MEM_OE_N_O(oe), .MEM_WE_N_O(we));
   pcmc_mem_model u_mem (.ce_n_i(ce), .oe_n_i(oe), .we_n_i(we), .addr_i(ma), .dq_i(dqo), .fault_i(fault),
      .dq_o(dqi));
   // ==========================================
   // Bus tasks
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pa <= a;
      pwr <= w;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      r = prd;
      slv = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [31:0] c);
      apb(REG_CTRL, 1'b1, c);
      apb(REG_STAT, 1'b0, 32'h0000_0000);
      while (r[STAT_BUSY_POS] !== 1'b0) apb(REG_STAT, 1'b0, 32'h0000_0000);
   endtask
   task automatic rd_arr(input logic [31:0] a, input logic [15:0] e);
      apb(REG_ADDR, 1'b1, a);
      op(32'(OP_READ_ARRAY));
      apb(REG_RDATA, 1'b0, 32'h0000_0000);
      chk(r, 32'(e));
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      apb(8'h18, 1'b0, 32'h0000_0000);
      chk({r[30:0], slv}, 32'h0000_0001);
      apb(REG_COUNT, 1'b1, 32'hFFFF_FFFF);
      apb(REG_COUNT, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_001F);
      apb(REG_ADDR, 1'b1, 32'h0001_FFF0);
      apb(REG_CTRL, 1'b1, 32'(OP_BUF_PROG));
      apb(REG_STAT, 1'b0, 32'h0000_0000);
      chk(32'(r[1:0]), 32'h0000_0002);
   endtask
   task automatic t_susp;
      apb(REG_ADDR, 1'b1, 32'h0000_0000);
      op(32'(OP_SUSPEND));
      chk(32'(r[15:0]), 32'h0000_8000);
      apb(REG_CTRL, 1'b1, 32'(OP_RESUME));
      apb(REG_STAT, 1'b0, 32'h0000_0000);
      chk(32'(r[STAT_REFUSED_POS]), 32'h0000_0001);
      fault <= 1'b1;
      op(32'(OP_SUSPEND));
      fault <= 1'b0;
      chk(32'(r[15:0]), 32'h0000_8408);
      apb(REG_CTRL, 1'b1, 32'(OP_READ_ARRAY));
      apb(REG_STAT, 1'b0, 32'h0000_0000);
      chk(32'(r[STAT_REFUSED_POS]), 32'h0000_0001);
      rd_arr(32'h0001_0000, 16'hFFFF);
      apb(REG_ADDR, 1'b1, 32'h0000_0000);
      op(32'(OP_RESUME));
      chk(32'(r[3:1]), 32'h0000_0000);
   endtask
   task automatic t_buf(input logic ba, input logic [22:0] a, input logic [15:0] s, input logic [15:0] d0,
      input logic [15:0] d1);
      apb(REG_ADDR, 1'b1, 32'(a));
      apb(REG_COUNT, 1'b1, 32'h0000_0001);
      apb(REG_WDATA, 1'b1, 32'(d0));
      apb(REG_WDATA, 1'b1, 32'(d1));
      op({27'h000_0000, ba, OP_BUF_PROG});
      chk(32'(r[15:0]), 32'(s));
      rd_arr(32'(a), d0);
      rd_arr(32'(a + 23'h00_0001), d1);
   endtask
   task automatic t_erase;
      apb(REG_ADDR, 1'b1, 32'h0001_0000);
      op(32'(OP_ERASE));
      rd_arr(32'h0001_0001, 16'hFFFF);
      fault <= 1'b1;
      op(32'(OP_ERASE));
      fault <= 1'b0;
      chk({r[15:8], 23'h00_0000, r[STAT_ERR_POS]}, 32'hA000_0001);
      apb(REG_CTRL, 1'b1, 32'(OP_ERASE));
      apb(REG_STAT, 1'b0, 32'h0000_0000);
      chk(32'(r[STAT_REFUSED_POS]), 32'h0000_0001);
      op(32'(OP_STATUS));
      chk(32'(r[15:8]), 32'h0000_00A0);
      op(32'(OP_CLEAR));
      op(32'(OP_STATUS));
      chk(32'(r[15:0]), 32'h0000_8000);
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_susp;
      t_buf(1'b0, 23'h01_0000, 16'h8000, 16'h1234, 16'hABCD);
      t_buf(1'b1, 23'h01_0002, 16'h8010, 16'h5A5A, 16'h0F0F);
      t_erase;
      wrap_up;
   end
   // Generous against roughly 56 memory cycles of 45 clocks
   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end
endmodule
bind pcmc_host pcmc_host_chk u_chk (.*);
